// file: pkg/cldf_consts.svh
// constant definitions for the coil line diagnosis and fault block
`ifndef CLDF_CONSTS_SVH
`define CLDF_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CLDF_ADDR_CMD       8'h00
`define CLDF_ADDR_READBACK  8'h04
`define CLDF_ADDR_FAULT     8'h08
`define CLDF_ADDR_STATUS    8'h0C

// ****************************************
// command byte layout
// ****************************************
`define CLDF_OP_MSB         7
`define CLDF_OP_LSB         5
`define CLDF_OP_SELECT      3'h1
`define CLDF_OP_CURRENT     3'h5
`define CLDF_DM_BIT         3
`define CLDF_CODE_MSB       2
`define CLDF_CODE_LSB       0
`define CLDF_POS_BIT        0
`define CLDF_RET_BIT        1
`define CLDF_ADDR_MSB       7
`define CLDF_CMD_GET_SETUP  8'h68
`define CLDF_CMD_FAULT_CLR  8'hC0

// ****************************************
// channel codes, high group and low group
// ****************************************
`define CLDF_CODE_CH1       3'h1
`define CLDF_CODE_CH2       3'h2
`define CLDF_CODE_CH3       3'h3
`define CLDF_CODE_CH4       3'h5
`define CLDF_CODE_CH5       3'h6
`define CLDF_CODE_CH6       3'h7

// ****************************************
// reset values and bus answers
// ****************************************
`define CLDF_CHAN_RESET     3'h0
`define CLDF_BITS_RESET     6'h00
`define CLDF_BYTE_RESET     8'h00
`define CLDF_WORD_ZERO      32'h0000_0000
`define CLDF_HRESP_OKAY     1'b0

`endif

// file: pkg/cldf_pkg.sv
// types shared by the coil line diagnosis and fault block
package cldf_pkg;

   localparam int CLDF_NCH = 6;

   // ****************************************
   // operating modes
   // ****************************************
   typedef enum logic [1:0] {
      CLDF_MODE_RUN,
      CLDF_MODE_SHUTDOWN,
      CLDF_MODE_DIAG
   } cldf_mode_t;

   // ****************************************
   // fault cause record
   // ****************************************
   typedef struct packed {
      logic       over_temp;
      logic       open_load;
      logic       short_ret;
      logic       short_pos;
   } cldf_cause_t;

   // ****************************************
   // asynchronous analog monitor inputs
   // ****************************************
   typedef struct packed {
      logic       over_temp;
      logic [5:0] open_load;
      logic [5:0] short_ret;
      logic [5:0] short_pos;
      logic [5:0] ret_cmp;
      logic [5:0] pos_cmp;
   } cldf_mon_t;

endpackage : cldf_pkg

// file: hw/cldf_top.sv
// coil line fault protection and diagnosis logic with AHB-Lite register slave
// Operation
// - any line short: all drivers high impedance
// - fault shutdown disconnects the sense shunt
// - shutdown cause stored in fault register
// - fault shutdown raises interrupt request
// - open load, overtemperature also shut down
// - fault monitoring runs continuously except in diagnosis mode, no command
// - fault clear with no fault left: register reset, operation resumes
// - diagnosis mode: drivers high impedance
// - diagnosis: all six test structures active
// - one bit per line picks high/low
// - selected channel bits from current command
// - A0h to A3h switch combinations
// - per-channel latch keeps other channels
// - changes only in diagnosis, selected channel
// - line comparator bit reads one above threshold
// - first diagnosis entry: low sides closed
// - select with mode bit enters diagnosis
// - setup read returns code and comparators
// - positive and return structures independent
`timescale 1ns/100ps
`include "cldf_consts.svh"

module cldf_top
   import cldf_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // analog monitors, asynchronous
   input  wire cldf_mon_t   mon_raw,
   // driver and shunt control
   output logic             drv_hiz_q,
   output logic             shunt_disc_q,
   output logic             fault_irq_q,
   output logic             diag_active_q,
   // test current source switches
   output logic [5:0]       pos_line_high_src_switch_q,
   output logic [5:0]       pos_line_low_src_switch_q,
   output logic [5:0]       ret_line_high_src_switch_q,
   output logic [5:0]       ret_line_low_src_switch_q
);

   // ****************************************
   // declarations
   // ****************************************
   cldf_mon_t   mon_meta_q;
   cldf_mon_t   mon_q;
   cldf_mode_t  mode_q;
   cldf_cause_t cause_q;
   cldf_cause_t cause_now;
   logic [11:0] short_lines_q;
   logic [2:0]  chan_code_q;
   logic [2:0]  chan_idx;
   logic        chan_ok;
   logic        exit_pend_q;
   logic        diag_seen_q;
   logic [5:0]  pos_line_test_bit_q;
   logic [5:0]  ret_line_test_bit_q;
   logic [5:0]  pos_line_test_bit_d;
   logic [5:0]  ret_line_test_bit_d;
   logic [7:0]  readback_q;
   logic [7:0]  last_cmd_q;
   logic        dph_wr_q;
   logic [7:0]  dph_addr_q;
   logic        aph_take;
   logic        cmd_stb;
   logic [7:0]  cmd;
   logic [2:0]  cmd_op;
   logic        is_select;
   logic        is_current;
   logic        is_get;
   logic        is_fclr;
   logic        fault_any;
   logic        shutdown_evt;
   logic        diag_enter;
   logic [31:0] rdata_d;

   // ****************************************
   // comparator and monitor synchroniser
   // ****************************************
   // two flops first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mon_meta_q <= '0;
         mon_q      <= '0;
      end else begin
         mon_meta_q <= mon_raw;
         mon_q      <= mon_meta_q;
      end
   end

   // ****************************************
   // ahb-lite address and data phase
   // ****************************************
   assign aph_take = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_q   <= 1'b0;
         dph_addr_q <= `CLDF_BYTE_RESET;
         hreadyout  <= 1'b1;
         hresp      <= `CLDF_HRESP_OKAY;
      end else begin
         dph_wr_q   <= aph_take && hwrite;
         dph_addr_q <= haddr[`CLDF_ADDR_MSB:0];
         hreadyout  <= 1'b1;
         hresp      <= `CLDF_HRESP_OKAY;
      end
   end

   // ****************************************
   // command decode
   // ****************************************
   assign cmd_stb    = dph_wr_q && (dph_addr_q == `CLDF_ADDR_CMD);
   assign cmd        = hwdata[7:0];
   assign cmd_op     = cmd[`CLDF_OP_MSB:`CLDF_OP_LSB];
   assign is_select  = cmd_stb && (cmd_op == `CLDF_OP_SELECT);
   assign is_current = cmd_stb && (cmd_op == `CLDF_OP_CURRENT);
   assign is_get     = cmd_stb && (cmd == `CLDF_CMD_GET_SETUP);
   assign is_fclr    = cmd_stb && (cmd == `CLDF_CMD_FAULT_CLR);

   // channel code to channel index
   always_comb begin
      chan_ok  = 1'b1;
      chan_idx = 3'h0;
      case (chan_code_q)
         `CLDF_CODE_CH1: chan_idx = 3'h0;
         `CLDF_CODE_CH2: chan_idx = 3'h1;
         `CLDF_CODE_CH3: chan_idx = 3'h2;
         `CLDF_CODE_CH4: chan_idx = 3'h3;
         `CLDF_CODE_CH5: chan_idx = 3'h4;
         `CLDF_CODE_CH6: chan_idx = 3'h5;
         default: chan_ok = 1'b0;
      endcase
   end

   // ****************************************
   // fault detection
   // ****************************************
   // short, open load, overtemperature
   always_comb begin
      cause_now.short_pos = |mon_q.short_pos;
      cause_now.short_ret = |mon_q.short_ret;
      cause_now.open_load = |mon_q.open_load;
      cause_now.over_temp = mon_q.over_temp;
   end

   assign fault_any    = |cause_now;
   assign shutdown_evt = fault_any && (mode_q != CLDF_MODE_DIAG);
   assign diag_enter   = is_select && cmd[`CLDF_DM_BIT] && (mode_q != CLDF_MODE_DIAG);

   // ****************************************
   // mode state machine
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= CLDF_MODE_RUN;
      end else begin
         case (mode_q)
            CLDF_MODE_RUN: begin
               if (fault_any) begin
                  mode_q <= CLDF_MODE_SHUTDOWN;
               end else if (diag_enter) begin
                  mode_q <= CLDF_MODE_DIAG;
               end
            end
            CLDF_MODE_SHUTDOWN: begin
               if (diag_enter) begin
                  mode_q <= CLDF_MODE_DIAG;
               end else if (is_fclr && !fault_any) begin
                  mode_q <= CLDF_MODE_RUN;
               end
            end
            CLDF_MODE_DIAG: begin
               if (is_fclr && exit_pend_q) begin
                  mode_q <= CLDF_MODE_RUN;
               end
            end
            default: mode_q <= CLDF_MODE_RUN;
         endcase
      end
   end

   // channel selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_code_q <= `CLDF_CHAN_RESET;
      end else if (is_select) begin
         chan_code_q <= cmd[`CLDF_CODE_MSB:`CLDF_CODE_LSB];
      end
   end

   // exit request, a select with mode bit cancels it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exit_pend_q <= 1'b0;
      end else if (is_select) begin
         exit_pend_q <= !cmd[`CLDF_DM_BIT];
      end else if (mode_q != CLDF_MODE_DIAG) begin
         exit_pend_q <= 1'b0;
      end
   end

   // ****************************************
   // fault register, sticky
   // ****************************************
   // cause kept until fault clear, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_q       <= '0;
         short_lines_q <= '0;
      end else if (is_fclr) begin
         cause_q       <= shutdown_evt ? cause_now : '0;
         short_lines_q <= shutdown_evt ? {mon_q.short_ret, mon_q.short_pos} : '0;
      end else if (shutdown_evt) begin
         cause_q       <= cause_q | cause_now;
         short_lines_q <= short_lines_q | {mon_q.short_ret, mon_q.short_pos};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_irq_q <= 1'b0;
      end else if (shutdown_evt) begin
         fault_irq_q <= 1'b1;
      end else if (is_fclr) begin
         fault_irq_q <= 1'b0;
      end
   end

   // ****************************************
   // driver and shunt control
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drv_hiz_q     <= 1'b1;
         shunt_disc_q  <= 1'b1;
         diag_active_q <= 1'b0;
      end else begin
         drv_hiz_q     <= shutdown_evt || (mode_q != CLDF_MODE_RUN) || diag_enter;
         shunt_disc_q  <= shutdown_evt || (mode_q == CLDF_MODE_SHUTDOWN);
         diag_active_q <= (mode_q == CLDF_MODE_DIAG) || diag_enter;
      end
   end

   // ****************************************
   // test switch latches
   // ****************************************
   always_comb begin
      pos_line_test_bit_d = pos_line_test_bit_q;
      ret_line_test_bit_d = ret_line_test_bit_q;
      if (diag_enter && !diag_seen_q) begin
         pos_line_test_bit_d = `CLDF_BITS_RESET;
         ret_line_test_bit_d = `CLDF_BITS_RESET;
      end
      if (is_current && (mode_q == CLDF_MODE_DIAG) && chan_ok) begin
         // bit 0 positive, bit 1 return
         pos_line_test_bit_d[chan_idx] = cmd[`CLDF_POS_BIT];
         ret_line_test_bit_d[chan_idx] = cmd[`CLDF_RET_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_line_test_bit_q <= `CLDF_BITS_RESET;
         ret_line_test_bit_q <= `CLDF_BITS_RESET;
      end else begin
         pos_line_test_bit_q <= pos_line_test_bit_d;
         ret_line_test_bit_q <= ret_line_test_bit_d;
      end
   end

   // first diagnosis entry seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_seen_q <= 1'b0;
      end else if (diag_enter) begin
         diag_seen_q <= 1'b1;
      end
   end

   // exactly one switch closed per line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_line_high_src_switch_q <= `CLDF_BITS_RESET;
         pos_line_low_src_switch_q  <= ~`CLDF_BITS_RESET;
         ret_line_high_src_switch_q <= `CLDF_BITS_RESET;
         ret_line_low_src_switch_q  <= ~`CLDF_BITS_RESET;
      end else begin
         pos_line_high_src_switch_q <= pos_line_test_bit_d;
         pos_line_low_src_switch_q  <= ~pos_line_test_bit_d;
         ret_line_high_src_switch_q <= ret_line_test_bit_d;
         ret_line_low_src_switch_q  <= ~ret_line_test_bit_d;
      end
   end

   // ****************************************
   // setup read-back and command echo
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_cmd_q <= `CLDF_BYTE_RESET;
      end else if (cmd_stb) begin
         last_cmd_q <= cmd;
      end
   end

   // code, positive bit 3, return bit 4
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         readback_q <= `CLDF_BYTE_RESET;
      end else if (is_get) begin
         readback_q <= {3'h0,
                        chan_ok && mon_q.ret_cmp[chan_idx],
                        chan_ok && mon_q.pos_cmp[chan_idx],
                        chan_code_q};
      end
   end

   // ****************************************
   // read data, decoded in address phase
   // ****************************************
   always_comb begin
      rdata_d = `CLDF_WORD_ZERO;
      if (haddr[`CLDF_ADDR_MSB:0] == `CLDF_ADDR_CMD) begin
         rdata_d[7:0] = last_cmd_q;
      end else if (haddr[`CLDF_ADDR_MSB:0] == `CLDF_ADDR_READBACK) begin
         rdata_d[7:0] = readback_q;
      end else if (haddr[`CLDF_ADDR_MSB:0] == `CLDF_ADDR_FAULT) begin
         rdata_d[15:0] = {short_lines_q, cause_q};
      end else if (haddr[`CLDF_ADDR_MSB:0] == `CLDF_ADDR_STATUS) begin
         rdata_d[9:0] = {diag_seen_q, exit_pend_q, fault_irq_q,
                         mode_q == CLDF_MODE_DIAG, mode_q == CLDF_MODE_SHUTDOWN,
                         chan_ok, chan_code_q, mon_q.over_temp};
      end
   end

   // captured in address phase, stands through data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `CLDF_WORD_ZERO;
      end else if (aph_take && !hwrite) begin
         hrdata <= rdata_d;
      end
   end

endmodule : cldf_top

// file: test/cldf_top_chk.sv
// assertion checker for the coil line fault and diagnosis block
`timescale 1ns/100ps
module cldf_top_chk
   import cldf_pkg::*;
(
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // monitors and controls
   input wire cldf_mon_t   mon_raw,
   input wire logic        drv_hiz_q,
   input wire logic        shunt_disc_q,
   input wire logic        fault_irq_q,
   input wire logic        diag_active_q,
   input wire logic [5:0]  pos_line_high_src_switch_q,
   input wire logic [5:0]  pos_line_low_src_switch_q,
   input wire logic [5:0]  ret_line_high_src_switch_q,
   input wire logic [5:0]  ret_line_low_src_switch_q
);
   wire logic sh = |{mon_raw.short_pos, mon_raw.short_ret};
   wire logic ol = |{mon_raw.open_load, mon_raw.over_temp};
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_short_hiz; !diag_active_q && $rose(sh) |-> ##[1:3] drv_hiz_q; endproperty
   a_short_hiz: assert property (p_short_hiz) else $error("short left drivers on");
   property p_shunt; $rose(fault_irq_q) |-> shunt_disc_q && drv_hiz_q; endproperty
   a_shunt: assert property (p_shunt) else $error("shunt kept on fault");
   property p_irq; !diag_active_q && $rose(sh || ol) |-> ##[1:3] fault_irq_q; endproperty
   a_irq: assert property (p_irq) else $error("no irq on fault");
   property p_open_hiz; !diag_active_q && $rose(ol) |-> ##[1:3] drv_hiz_q && shunt_disc_q; endproperty
   a_open_hiz: assert property (p_open_hiz) else $error("open or hot not shut down");
   property p_diag_hiz; diag_active_q |-> drv_hiz_q; endproperty
   a_diag_hiz: assert property (p_diag_hiz) else $error("drivers on in diagnosis");
   property p_one_sw;
      &(pos_line_high_src_switch_q ^ pos_line_low_src_switch_q) &&
      &(ret_line_high_src_switch_q ^ ret_line_low_src_switch_q);
   endproperty
   a_one_sw: assert property (p_one_sw) else $error("switch pair not exclusive");
   property p_hold;
      !diag_active_q ##1 !diag_active_q |-> $stable({pos_line_high_src_switch_q, ret_line_high_src_switch_q});
   endproperty
   a_hold: assert property (p_hold) else $error("switch moved outside diagnosis");
   property p_one_ch;
      diag_active_q && $past(diag_active_q) |-> $onehot0((pos_line_high_src_switch_q ^
         $past(pos_line_high_src_switch_q)) | (ret_line_high_src_switch_q ^ $past(ret_line_high_src_switch_q)));
   endproperty
   a_one_ch: assert property (p_one_ch) else $error("several channels changed");
   property p_sync; !drv_hiz_q && $rose(sh) |=> !drv_hiz_q [*2]; endproperty
   a_sync: assert property (p_sync) else $error("fault acted before sync");
endmodule : cldf_top_chk

// file: test/cldf_line_model.sv
// coil line model: comparators follow test sources or injected comparator values
`timescale 1ns/100ps
module cldf_line_model
   import cldf_pkg::*;
(
   // test source switches
   input  wire logic [5:0] pos_hi,
   input  wire logic [5:0] ret_hi,
   // injected line faults
   input  wire cldf_mon_t  inj,
   // monitor outputs
   output cldf_mon_t       mon
);
   always_comb begin
      mon         = inj;
      mon.pos_cmp = pos_hi | inj.pos_cmp;
      mon.ret_cmp = ret_hi | inj.ret_cmp;
   end
endmodule : cldf_line_model

// file: test/cldf_top_test.sv
// self-checking bench for the coil line fault and diagnosis block
`timescale 1ns/100ps
`include "cldf_consts.svh"
module cldf_top_test
   import cldf_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        drv_hiz_q, shunt_disc_q, fault_irq_q, diag_active_q;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [5:0]  ph, pl, rh, rl;
   cldf_mon_t   inj, mon;
   int          fails, checks_done;

   cldf_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .mon_raw(mon), .drv_hiz_q, .shunt_disc_q, .fault_irq_q, .diag_active_q,
      .pos_line_high_src_switch_q(ph), .pos_line_low_src_switch_q(pl), .ret_line_high_src_switch_q(rh),
      .ret_line_low_src_switch_q(rl));
   cldf_line_model lines (.pos_hi(ph), .ret_hi(rh), .inj, .mon);

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // *****
   // bus and compare helpers
   // *****
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task cmd(input logic [7:0] c);
      bus(1'b1, `CLDF_ADDR_CMD, c);
      repeat (3) @(posedge hclk);
   endtask : cmd

   task setup(input logic [7:0] e);
      cmd(`CLDF_CMD_GET_SETUP);
      bus(1'b0, `CLDF_ADDR_READBACK, 8'h00);
      chk(rd, {24'h000000, e});
   endtask : setup

   task flags(input logic [2:0] e);
      chk({29'h0, drv_hiz_q, fault_irq_q, diag_active_q}, {29'h0, e});
   endtask : flags

   task sw(input logic [5:0] eph, input logic [5:0] erh);
      chk({8'h00, ph, pl, rh, rl}, {8'h00, eph, ~eph, erh, ~erh});
   endtask : sw

   // *****
   // scenarios
   // *****
   task t_reset;
      repeat (2) @(posedge hclk);
      flags(3'b000);
      sw(6'h00, 6'h00);
      bus(1'b0, `CLDF_ADDR_FAULT, 8'h00);
      chk(rd, 32'h0000_0000);
      chk({31'h0, hresp}, 32'h0000_0000);
      bus(1'b1, 8'h10, 8'hC0);
      bus(1'b0, 8'h10, 8'h00);
      chk(rd, 32'h0000_0000);
      $display("reset test done");
   endtask : t_reset

   task t_faults;
      cldf_mon_t   f;
      logic [31:0] e;
      for (int i = 0; i < 4; i++) begin
         f = '0;
         case (i)
            0: begin f.short_pos[2] = 1'b1; e = 32'h0000_0041; end
            1: begin f.short_ret[4] = 1'b1; e = 32'h0000_4002; end
            2: begin f.open_load[0] = 1'b1; e = 32'h0000_0004; end
            default: begin f.over_temp = 1'b1; e = 32'h0000_0008; end
         endcase
         inj <= f;
         repeat (5) @(posedge hclk);
         flags(3'b110);
         chk({31'h0, shunt_disc_q}, 32'h0000_0001);
         inj <= '0;
         repeat (4) @(posedge hclk);
         bus(1'b0, `CLDF_ADDR_FAULT, 8'h00);
         chk(rd, e);
         cmd(`CLDF_CMD_FAULT_CLR);
         flags(3'b000);
         chk({31'h0, shunt_disc_q}, 32'h0000_0000);
         bus(1'b0, `CLDF_ADDR_FAULT, 8'h00);
         chk(rd, 32'h0000_0000);
      end
      $display("fault test done");
   endtask : t_faults

   task t_diag;
      cmd(8'h29);
      flags(3'b101);
      sw(6'h00, 6'h00);
      setup(8'h01);
      cmd(8'hA1);
      sw(6'h01, 6'h00);
      setup(8'h09);
      cmd(8'h2D);
      cmd(8'hA2);
      sw(6'h01, 6'h08);
      setup(8'h15);
      cmd(8'hA3);
      sw(6'h09, 6'h08);
      cmd(8'hA0);
      sw(6'h01, 6'h00);
      $display("diagnosis test done");
   endtask : t_diag

   task t_exit;
      cmd(`CLDF_CMD_FAULT_CLR);
      flags(3'b101);
      cmd(8'h21);
      cmd(`CLDF_CMD_FAULT_CLR);
      flags(3'b000);
      cmd(8'hA2);
      sw(6'h01, 6'h00);
      cmd(8'h2A);
      sw(6'h01, 6'h00);
      cmd(8'hA1);
      sw(6'h03, 6'h00);
      setup(8'h0A);
      cmd(8'h22);
      cmd(`CLDF_CMD_FAULT_CLR);
      flags(3'b000);
      $display("exit test done");
   endtask : t_exit

   task t_codes;
      cmd(8'h2F);
      flags(3'b101);
      sw(6'h03, 6'h00);
      cmd(8'hA1);
      sw(6'h23, 6'h00);
      setup(8'h0F);
      cmd(8'h28);
      cmd(8'hA3);
      sw(6'h23, 6'h00);
      setup(8'h00);
      cmd(8'h20);
      cmd(`CLDF_CMD_FAULT_CLR);
      flags(3'b000);
      $display("channel code test done");
   endtask : t_codes

   task t_clear_hold;
      cldf_mon_t f;
      f = '0;
      f.short_pos[0] = 1'b1;
      inj <= f;
      repeat (5) @(posedge hclk);
      flags(3'b110);
      cmd(`CLDF_CMD_FAULT_CLR);
      flags(3'b110);
      bus(1'b0, `CLDF_ADDR_FAULT, 8'h00);
      chk(rd, 32'h0000_0011);
      inj <= '0;
      repeat (4) @(posedge hclk);
      cmd(`CLDF_CMD_FAULT_CLR);
      flags(3'b000);
      chk({31'h0, shunt_disc_q}, 32'h0000_0000);
      $display("clear with fault test done");
   endtask : t_clear_hold

   task test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      haddr   = 32'h0000_0000;
      hwdata  = 32'h0000_0000;
      inj     = '0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_faults;
      t_diag;
      t_exit;
      t_codes;
      t_clear_hold;
      test_done;
   end

   initial begin
      #100000;
      fails++;
      $display("CHECK FAILED at %0t: timeout", $time);
      test_done;
   end
endmodule : cldf_top_test

bind cldf_top cldf_top_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
   .hreadyout, .hresp, .hrdata, .mon_raw, .drv_hiz_q, .shunt_disc_q, .fault_irq_q, .diag_active_q,
   .pos_line_high_src_switch_q, .pos_line_low_src_switch_q, .ret_line_high_src_switch_q,
   .ret_line_low_src_switch_q);
